// >>> hw/rom_code_protection_lock.sv
`timescale 1ns/10ps
module rom_code_protection_lock
   import rom_protect_pkg::*;
#(
   parameter int CODE_ADDR_W = CODE_ADDR_W_DEF
) (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic [BUS_ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic [BUS_DATA_W-1:0] AVS_WRITEDATA_IN,
   output logic [BUS_DATA_W-1:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic [1:0] PROTECTION_BITS_BYTE_IN,
   input wire logic EXTERNAL_ACCESS_PIN_IN,
   output logic EXTERNAL_ACCESS_OUT,
   input wire logic CODE_TABLE_READ_VALID_IN,
   input wire logic CODE_TABLE_READ_FROM_EXT_IN,
   input wire logic [7:0] CODE_TABLE_ROM_DATA_IN,
   output logic [7:0] CODE_TABLE_READ_DATA_OUT,
   output logic CODE_TABLE_READ_VALID_OUT,
   output logic CODE_TABLE_READ_BLOCKED_OUT,
   output logic [CODE_ADDR_W-1:0] VERIFY_ADDR_OUT,
   input wire logic [7:0] VERIFY_ROM_DATA_IN,
   output logic PROG_WRITE_OUT,
   output logic [7:0] PROG_DATA_OUT
);

   generate
      if (CODE_ADDR_W < KEY_IDX_W || CODE_ADDR_W > 16) begin : g_bad_width
         $error("CODE_ADDR_W must lie between 6 and 16");
      end
   endgenerate

   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   logic lock_one;
   logic lock_two;
   logic ea_latched;
   logic keyed;
   logic refused;
   logic [7:0] key [KEY_BYTES];

   // Bus request decode
   wire req = AVS_READ_IN | AVS_WRITE_IN;
   wire take = req & ~AVS_WAITREQUEST_OUT;
   wire wr_take = take & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
   wire rd_load = AVS_READ_IN & AVS_WAITREQUEST_OUT;
   wire hit_status = (AVS_ADDRESS_IN == OFS_STATUS);
   wire hit_vaddr = (AVS_ADDRESS_IN == OFS_VERIFY_ADDR);
   wire hit_vdata = (AVS_ADDRESS_IN == OFS_VERIFY_DATA);
   wire hit_prog = (AVS_ADDRESS_IN == OFS_PROG_DATA);
   wire hit_key = (AVS_ADDRESS_IN == OFS_KEY_WRITE);

   // Lock two counts only alongside lock one
   wire lock_two_eff = lock_two & lock_one;

   // Verify output, scrambled when keyed
   wire [KEY_IDX_W-1:0] key_idx = VERIFY_ADDR_OUT[KEY_IDX_W-1:0];
   wire [7:0] scrambled = ~(VERIFY_ROM_DATA_IN ^ key[key_idx]);
   wire [7:0] verify_byte = keyed ? scrambled : VERIFY_ROM_DATA_IN;
   wire [7:0] verify_out = lock_two_eff ? 8'h00 : verify_byte;

   // Status word from named field positions
   logic [BUS_DATA_W-1:0] status_word;
   always_comb begin
      status_word = READ_ZERO;
      status_word[ST_LOCK_ONE] = lock_one;
      status_word[ST_LOCK_TWO] = lock_two;
      status_word[ST_KEYED] = keyed;
      status_word[ST_EA_LATCH] = ea_latched;
      status_word[ST_REFUSED] = refused;
   end

   // Key bytes are never returned; the lock bits are returned only in the status word
   wire [BUS_DATA_W-1:0] next_readdata =
      hit_status ? status_word :
      hit_vaddr ? {{(BUS_DATA_W-CODE_ADDR_W){1'b0}}, VERIFY_ADDR_OUT} :
      hit_vdata ? {24'h00_0000, verify_out} :
      READ_ZERO;

   wire prog_try = wr_take & hit_prog;
   wire key_try = wr_take & hit_key;
   wire key_ok = key_try & ~lock_one;
   wire [KEY_IDX_W-1:0] key_wr_idx = AVS_WRITEDATA_IN[KEY_WR_IDX_LSB +: KEY_IDX_W];
   wire refuse_evt = (prog_try | key_try) & lock_one;
   wire clr_refused = wr_take & hit_status & AVS_WRITEDATA_IN[ST_REFUSED];
   wire table_block = CODE_TABLE_READ_FROM_EXT_IN & lock_one;

   // Lock state captured while reset is held
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         lock_one <= PROTECTION_BITS_BYTE_IN[LOCK_ONE_BIT];
         lock_two <= PROTECTION_BITS_BYTE_IN[LOCK_TWO_BIT];
         ea_latched <= EXTERNAL_ACCESS_PIN_IN;
      end
   end

   // Access pin frozen under lock one
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         EXTERNAL_ACCESS_OUT <= 1'b0;
      end else begin
         EXTERNAL_ACCESS_OUT <= lock_one ? ea_latched : EXTERNAL_ACCESS_PIN_IN;
      end
   end

   // Key array, all ones until written
   generate
      for (genvar i = 0; i < KEY_BYTES; i++) begin : g_key
         always_ff @(posedge CLOCK_IN) begin
            if (!RST_N_IN) begin
               key[i] <= KEY_RESET;
            end else if (key_ok && key_wr_idx == KEY_IDX_W'(i)) begin
               key[i] <= AVS_WRITEDATA_IN[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         keyed <= 1'b0;
      end else if (key_ok) begin
         keyed <= 1'b1;
      end
   end

   // Sticky refusal flag, set beats clear
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         refused <= 1'b0;
      end else if (refuse_evt) begin
         refused <= 1'b1;
      end else if (clr_refused) begin
         refused <= 1'b0;
      end
   end

   // Bus slave: one wait cycle per request
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end else begin
         AVS_WAITREQUEST_OUT <= ~(req & AVS_WAITREQUEST_OUT);
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         AVS_READDATA_OUT <= READ_ZERO;
      end else if (rd_load) begin
         AVS_READDATA_OUT <= next_readdata;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         VERIFY_ADDR_OUT <= '0;
      end else if (wr_take && hit_vaddr) begin
         VERIFY_ADDR_OUT <= AVS_WRITEDATA_IN[CODE_ADDR_W-1:0];
      end
   end

   // Programming strobe, withheld under lock one
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         PROG_WRITE_OUT <= 1'b0;
         PROG_DATA_OUT <= 8'h00;
      end else begin
         PROG_WRITE_OUT <= prog_try & ~lock_one;
         if (prog_try && !lock_one) begin
            PROG_DATA_OUT <= AVS_WRITEDATA_IN[7:0];
         end
      end
   end

   // Table read path
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         CODE_TABLE_READ_VALID_OUT <= 1'b0;
         CODE_TABLE_READ_BLOCKED_OUT <= 1'b0;
         CODE_TABLE_READ_DATA_OUT <= 8'h00;
      end else begin
         CODE_TABLE_READ_VALID_OUT <= CODE_TABLE_READ_VALID_IN;
         CODE_TABLE_READ_BLOCKED_OUT <= CODE_TABLE_READ_VALID_IN & table_block;
         if (CODE_TABLE_READ_VALID_IN) begin
            CODE_TABLE_READ_DATA_OUT <= table_block ? 8'h00 : CODE_TABLE_ROM_DATA_IN;
         end
      end
   end

   // Checks
   property p_verify_plain;
      (rd_load && hit_vdata && !keyed && !lock_two_eff)
         |=> AVS_READDATA_OUT == {24'h00_0000, $past(VERIFY_ROM_DATA_IN)};
   endproperty
   a_verify_plain: assert property (p_verify_plain) else $error("plain verify wrong");

   property p_table_block;
      (CODE_TABLE_READ_VALID_IN && CODE_TABLE_READ_FROM_EXT_IN && lock_one)
         |=> CODE_TABLE_READ_BLOCKED_OUT && CODE_TABLE_READ_DATA_OUT == 8'h00;
   endproperty
   a_table_block: assert property (p_table_block) else $error("table read leaked");

   property p_ea_frozen;
      (RST_N_IN && lock_one) |=> EXTERNAL_ACCESS_OUT == ea_latched && $stable(ea_latched);
   endproperty
   a_ea_frozen: assert property (p_ea_frozen) else $error("access pin not latched");

   property p_prog_refused;
      (prog_try && lock_one) |=> !PROG_WRITE_OUT && refused;
   endproperty
   a_prog_refused: assert property (p_prog_refused) else $error("program not refused");

   property p_verify_inhibit;
      (rd_load && hit_vdata && lock_two_eff) |=> AVS_READDATA_OUT == READ_ZERO;
   endproperty
   a_verify_inhibit: assert property (p_verify_inhibit) else $error("verify not inhibited");

   property p_verify_scramble;
      (rd_load && hit_vdata && keyed && !lock_two_eff)
         |=> AVS_READDATA_OUT[7:0] == $past(scrambled);
   endproperty
   a_verify_scramble: assert property (p_verify_scramble) else $error("scramble wrong");

   property p_key_hidden;
      (rd_load && hit_key) |=> AVS_READDATA_OUT == READ_ZERO;
   endproperty
   a_key_hidden: assert property (p_key_hidden) else $error("key readable");

   property p_lock_const;
      ##1 ($stable(lock_one) && $stable(lock_two));
   endproperty
   a_lock_const: assert property (p_lock_const) else $error("lock state changed");

   property p_prog_ok;
      (prog_try && !lock_one) |=> PROG_WRITE_OUT ##1 !PROG_WRITE_OUT;
   endproperty
   a_prog_ok: assert property (p_prog_ok) else $error("program strobe wrong");

   property p_ea_follow;
      (RST_N_IN && !lock_one) |=> EXTERNAL_ACCESS_OUT == $past(EXTERNAL_ACCESS_PIN_IN);
   endproperty
   a_ea_follow: assert property (p_ea_follow) else $error("access pin not followed");

   property p_table_pass;
      (CODE_TABLE_READ_VALID_IN && !table_block)
         |=> CODE_TABLE_READ_VALID_OUT && !CODE_TABLE_READ_BLOCKED_OUT
            && CODE_TABLE_READ_DATA_OUT == $past(CODE_TABLE_ROM_DATA_IN);
   endproperty
   a_table_pass: assert property (p_table_pass) else $error("table read lost");

   property p_table_idle;
      !CODE_TABLE_READ_VALID_IN |=> !CODE_TABLE_READ_VALID_OUT
         && !CODE_TABLE_READ_BLOCKED_OUT && $stable(CODE_TABLE_READ_DATA_OUT);
   endproperty
   a_table_idle: assert property (p_table_idle) else $error("table output moved idle");

   property p_key_reset;
      !keyed |-> key[key_idx] == KEY_RESET;
   endproperty
   a_key_reset: assert property (p_key_reset) else $error("key not all ones");

   property p_key_store;
      key_ok |=> keyed
         && key[$past(key_wr_idx)] == $past(AVS_WRITEDATA_IN[7:0]);
   endproperty
   a_key_store: assert property (p_key_store) else $error("key byte not stored");

   property p_key_locked;
      (key_try && lock_one) |=> refused && $stable(keyed);
   endproperty
   a_key_locked: assert property (p_key_locked) else $error("key write not refused");

   property p_refused_hold;
      (refused && !clr_refused) |=> refused;
   endproperty
   a_refused_hold: assert property (p_refused_hold) else $error("refused flag lost");

   property p_status_locks;
      (rd_load && hit_status) |=> AVS_READDATA_OUT[ST_LOCK_ONE] == lock_one
         && AVS_READDATA_OUT[ST_LOCK_TWO] == lock_two;
   endproperty
   a_status_locks: assert property (p_status_locks) else $error("lock status wrong");

   property p_vdata_upper;
      (rd_load && hit_vdata) |=> AVS_READDATA_OUT[BUS_DATA_W-1:8] == 24'h00_0000;
   endproperty
   a_vdata_upper: assert property (p_vdata_upper) else $error("verify upper bits set");

   property p_vaddr_index;
      (wr_take && hit_vaddr) |=> key_idx == $past(AVS_WRITEDATA_IN[KEY_IDX_W-1:0]);
   endproperty
   a_vaddr_index: assert property (p_vaddr_index) else $error("key index wrong");

   property p_prog_data;
      (prog_try && !lock_one) |=> PROG_DATA_OUT == $past(AVS_WRITEDATA_IN[7:0]);
   endproperty
   a_prog_data: assert property (p_prog_data) else $error("program data wrong");

endmodule

// >>> hw/rom_protect_pkg.sv
// Behaviour
// - Unlocked: verify reads code, scrambled if keyed
// - Lock one: external table reads get no code
// - Lock one: access pin latched at reset
// - Lock one: further code programming refused
// - Lock two with lock one: verify read path inhibited
// - Only none, one, or both locks defined
// - Key holds 64 bytes, all ones unprogrammed
// - Keyed verify output is code XNOR key
// - Key contents never readable from outside
package rom_protect_pkg;
   localparam int BUS_ADDR_W = 8;
   localparam int BUS_DATA_W = 32;
   localparam int CODE_ADDR_W_DEF = 12;
   localparam int KEY_BYTES = 64;
   localparam int KEY_IDX_W = 6;
   localparam logic [7:0] KEY_RESET = 8'hFF;
   localparam logic [15:0] IMAGE_CODE_LAST = 16'h0FFF;
   localparam logic [15:0] IMAGE_KEY_FIRST = 16'h1000;
   localparam logic [15:0] IMAGE_LOCK_ADDR = 16'h1040;
   localparam int LOCK_ONE_BIT = 0;
   localparam int LOCK_TWO_BIT = 1;
   localparam logic [BUS_ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [BUS_ADDR_W-1:0] OFS_VERIFY_ADDR = 8'h04;
   localparam logic [BUS_ADDR_W-1:0] OFS_VERIFY_DATA = 8'h08;
   localparam logic [BUS_ADDR_W-1:0] OFS_PROG_DATA = 8'h0C;
   localparam logic [BUS_ADDR_W-1:0] OFS_KEY_WRITE = 8'h10;
   localparam int ST_LOCK_ONE = 0;
   localparam int ST_LOCK_TWO = 1;
   localparam int ST_KEYED = 2;
   localparam int ST_EA_LATCH = 3;
   localparam int ST_REFUSED = 4;
   localparam int KEY_WR_IDX_LSB = 8;
   localparam logic [BUS_DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// >>> verif/code_rom_model.sv
`timescale 1ns/10ps
module code_rom_model (
   input wire logic [11:0] addr_in,
   output logic [7:0] data_out
);
   // User code image, 4k locations of eight bits
   assign data_out = addr_in[7:0] ^ {addr_in[11:8], addr_in[11:8]};
endmodule

// >>> verif/tb_rom_code_protection_lock.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_rom_code_protection_lock;
   import rom_protect_pkg::*;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, ea = 0, tv = 0, tx = 0;
   logic wt, eao, tvo, tbo, pw;
   logic [7:0] adr = 8'h00, tdat = 8'h00, rom, tdo, pd;
   logic [3:0] be = 4'hF;
   logic [31:0] wd = 32'h0000_0000, rdo, q;
   logic [1:0] lk = 2'h0;
   logic [11:0] va;
   int mismatches = 0, comparisons = 0, pulses = 0;
   rom_code_protection_lock i_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(wd),
      .AVS_READDATA_OUT(rdo), .AVS_WAITREQUEST_OUT(wt), .PROTECTION_BITS_BYTE_IN(lk),
      .EXTERNAL_ACCESS_PIN_IN(ea), .EXTERNAL_ACCESS_OUT(eao), .CODE_TABLE_READ_VALID_IN(tv),
      .CODE_TABLE_READ_FROM_EXT_IN(tx), .CODE_TABLE_ROM_DATA_IN(tdat),
      .CODE_TABLE_READ_DATA_OUT(tdo), .CODE_TABLE_READ_VALID_OUT(tvo),
      .CODE_TABLE_READ_BLOCKED_OUT(tbo), .VERIFY_ADDR_OUT(va), .VERIFY_ROM_DATA_IN(rom),
      .PROG_WRITE_OUT(pw), .PROG_DATA_OUT(pd));
   code_rom_model i_rom (.addr_in(va), .data_out(rom));
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (pw === 1'b1) pulses++;
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
      r = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task run(input logic [1:0] l, input logic e);
      logic l1, l2;
      l1 = l[0];
      l2 = l[0] & l[1];
      rst_n <= 1'b0;
      lk <= l;
      ea <= e;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      lk <= (l == 2'h0) ? 2'h3 : 2'h0;
      acc(0, OFS_STATUS, 0, q);
      `CHK(q & 32'h0000_001F, {27'h0, 1'b0, e, 1'b0, l2, l1})
      ea <= ~e;
      repeat (3) @(posedge clk);
      `CHK(eao, l1 ? e : ~e)
      tv <= 1'b1;
      tx <= 1'b1;
      tdat <= 8'h5A;
      @(posedge clk);
      tv <= 1'b0;
      @(posedge clk);
      `CHK({tvo, tbo, tdo}, {1'b1, l1, l1 ? 8'h00 : 8'h5A})
      acc(1, OFS_VERIFY_ADDR, 32'h0000_03C5, q);
      acc(0, OFS_VERIFY_ADDR, 0, q);
      `CHK(q, 32'h0000_03C5)
      acc(0, OFS_VERIFY_DATA, 0, q);
      `CHK(q, {24'h0, l2 ? 8'h00 : 8'hF6})
      acc(1, OFS_KEY_WRITE, 32'h0000_053C, q);
      acc(0, OFS_VERIFY_DATA, 0, q);
      `CHK(q[7:0], l2 ? 8'h00 : (l1 ? 8'hF6 : ~(8'hF6 ^ 8'h3C)))
      acc(0, OFS_KEY_WRITE, 0, q);
      `CHK(q, 32'h0000_0000)
      acc(1, OFS_PROG_DATA, 32'h0000_00A7, q);
      @(posedge clk);
      `CHK(pd, l1 ? 8'h00 : 8'hA7)
      acc(0, OFS_STATUS, 0, q);
      `CHK(q & 32'h0000_0017, {27'h0, l1, 1'b0, !l1, l2, l1})
      acc(1, OFS_STATUS, 32'h0000_0010, q);
      acc(0, 8'h20, 0, q);
      `CHK(q, 32'h0000_0000)
      acc(0, OFS_STATUS, 0, q);
      `CHK(q[4], 1'b0)
   endtask
   initial begin
      run(2'h0, 1'b1);
      run(2'h1, 1'b1);
      run(2'h3, 1'b0);
      `CHK(pulses, 1)
      end_sim();
   end
endmodule
